// ---- design/fspc_ctrl.sv ----
// Purpose: run-time self-programming controller for program flash
// Assumes: rstn is power-on reset; sys_rst is any other reset, same clock
// Notes:   table port and flash array port run on clk without sync
`timescale 1ns/1ps
// Overview of operation
// - Target address is page select plus EA
// - Low table ops use word bits 15..0
// - High table ops use word bits 23..16
// - One page erase or two-word program
// - Stall processor while operation runs
// - Start bit launches; hardware clears on completion
// - Program pair sits on four-unit boundary
// - Key register is write-only protection
// - Address registers concatenate to 24 bits
// - Enable bit permits erase and program
// - Fault flag marks improper sequence
// - Standby bit idles regulator in Idle
// - Code 0011 erase, 0001 program
// - Control bits reset only at power-on; sys_rst still clears start bit
// - Power-save ignored while operation runs
// - Wake delay after Idle with standby
// - Start bit set by software only
// - Address registers read/write, power up unknown
// - Page select bit 7 selects configuration
// - Erase covers 1024 instructions
module fspc_ctrl
   import fspc_pkg::*;
(
   input  wire logic                      clk,          // System clock
   input  wire logic                      rstn,         // Power-on reset
   input  wire logic                      sys_rst,      // Other resets
   input  wire logic                      wb_cyc_i,     // Bus cycle
   input  wire logic                      wb_stb_i,     // Bus strobe
   input  wire logic                      wb_we_i,      // Bus write
   input  wire logic [7:0]                wb_adr_i,     // Byte address
   input  wire logic [3:0]                wb_sel_i,     // Byte selects
   input  wire logic [31:0]               wb_dat_i,     // Write data
   output logic      [31:0]               wb_dat_o,     // Read data
   output logic                           wb_ack_o,     // Bus ack
   input  wire logic                      tbl_valid,    // Table request
   input  wire fspc_pkg::fspc_tbl_req_t   tbl_req,      // Table details
   output logic                           tbl_ready,    // Request taken
   output logic                           tbl_rvalid,   // Fetch data pulse
   output logic      [15:0]               tbl_rdata,    // Fetch data
   output fspc_pkg::fspc_flash_cmd_t      fl_cmd,       // Array command
   input  wire logic                      fl_rd_ack,    // Array read done
   input  wire logic [23:0]               fl_rdata,     // Array read data
   input  wire logic                      fl_done,      // Array op done
   output logic                           cpu_stall,    // Stall core
   input  wire logic                      power_save_instruction_req,   // Power-save op
   output logic                           power_save_instruction_ok,    // Power-save taken
   input  wire logic                      idle_in,      // Core in Idle
   output logic                           reg_standby,  // Regulator off
   output logic                           flash_ready   // Flash usable
);
   import fspc_pkg::*;

   typedef enum logic [2:0] {
      FSPC_ST_IDLE,
      FSPC_ST_FETCH,
      FSPC_ST_LOAD,
      FSPC_ST_ISSUE,
      FSPC_ST_WAIT
   } fspc_state_t;

   fspc_state_t     state_q;
   fspc_key_t       key_q;
   logic            start_q;
   logic            en_q;
   logic            fault_q;
   logic            stby_q;
   logic [3:0]      op_q;
   logic [7:0]      upper_q;
   logic [15:0]     lower_q;
   logic [7:0]      page_q;
   logic            ack_q;
   logic [31:0]     dat_q;
   fspc_flash_cmd_t cmd_q;
   fspc_tbl_req_t   hold_q;
   logic            rvalid_q;
   logic [15:0]     rdata_q;
   logic            stby_out_q;
   logic            ready_q;
   logic [15:0]     wake_q;
   logic            mem_we;
   logic [2:0]      mem_be;
   logic [23:0]     mem_wd;
   logic [23:0]     mem_rd0;
   logic [23:0]     mem_rd1;
   logic            fire;
   logic            wr_fire;
   logic            ctrl_wr;
   logic            try_start;
   logic            op_valid;
   logic            accept;
   logic            bad_start;
   logic            busy;
   logic [23:0]     op_addr;

   assign busy      = (state_q == FSPC_ST_LOAD) || (state_q == FSPC_ST_ISSUE)
                   || (state_q == FSPC_ST_WAIT);
   assign fire      = wb_cyc_i && wb_stb_i && !ack_q;
   assign wr_fire   = fire && wb_we_i;
   assign ctrl_wr   = wr_fire && (wb_adr_i == FSPC_OFS_CTRL) && !busy;
   assign try_start = ctrl_wr && wb_sel_i[1] && wb_dat_i[FSPC_START_BIT];
   assign op_valid  = (op_q == FSPC_OP_ERASE) || (op_q == FSPC_OP_PROG);
   assign accept    = try_start && (key_q == FSPC_KEY_OPEN) && en_q
                   && op_valid && !sys_rst;
   assign bad_start = try_start && !accept;
   assign op_addr   = fspc_addr(upper_q, lower_q);

   assign cpu_stall   = busy;
   assign power_save_instruction_ok   = power_save_instruction_req && !busy;
   assign tbl_ready   = (state_q == FSPC_ST_IDLE) && !sys_rst && !accept;
   assign wb_ack_o    = ack_q;
   assign wb_dat_o    = dat_q;
   assign tbl_rvalid  = rvalid_q;
   assign tbl_rdata   = rdata_q;
   assign fl_cmd      = cmd_q;
   assign reg_standby = stby_out_q;
   assign flash_ready = ready_q;

   // Bus slave: one wait state, unmapped reads return zero
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ack_q <= 1'b0;
         dat_q <= 32'h00000000;
      end else begin
         ack_q <= fire;
         if (fire && !wb_we_i) begin
            case (wb_adr_i)
               FSPC_OFS_CTRL:  dat_q <= {16'h0000, start_q, en_q, fault_q,
                                         stby_q, 8'h00, op_q};
               FSPC_OFS_UPPER: dat_q <= {24'h000000, upper_q};
               FSPC_OFS_LOWER: dat_q <= {16'h0000, lower_q};
               FSPC_OFS_PAGE:  dat_q <= {24'h000000, page_q};
               default:        dat_q <= 32'h00000000;
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         en_q   <= FSPC_CTRL_RST[FSPC_EN_BIT];
         stby_q <= FSPC_CTRL_RST[FSPC_STBY_BIT];
         op_q   <= FSPC_CTRL_RST[3:0];
      end else if (ctrl_wr) begin
         if (wb_sel_i[1]) begin
            en_q   <= wb_dat_i[FSPC_EN_BIT];
            stby_q <= wb_dat_i[FSPC_STBY_BIT];
         end
         if (wb_sel_i[0]) begin
            op_q <= wb_dat_i[3:0];
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         start_q <= FSPC_CTRL_RST[FSPC_START_BIT];
      end else if (accept) begin
         start_q <= 1'b1;
      end else if ((state_q == FSPC_ST_WAIT && fl_done) || sys_rst) begin
         start_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fault_q <= FSPC_CTRL_RST[FSPC_FAULT_BIT];
      end else if (bad_start || (busy && sys_rst)) begin
         fault_q <= 1'b1;
      end else if (accept) begin
         fault_q <= 1'b0;
      end else if (ctrl_wr && wb_sel_i[1]) begin
         fault_q <= wb_dat_i[FSPC_FAULT_BIT];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         key_q <= FSPC_KEY_LOCKED;
      end else if (sys_rst) begin
         key_q <= FSPC_KEY_LOCKED;
      end else if (wr_fire) begin
         if (wb_adr_i == FSPC_OFS_KEY && wb_sel_i[0]
             && wb_dat_i[7:0] == FSPC_KEY_FIRST) begin
            key_q <= FSPC_KEY_HALF;
         end else if (wb_adr_i == FSPC_OFS_KEY && wb_sel_i[0]
                      && wb_dat_i[7:0] == FSPC_KEY_SECOND
                      && key_q == FSPC_KEY_HALF) begin
            key_q <= FSPC_KEY_OPEN;
         end else begin
            key_q <= FSPC_KEY_LOCKED;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (wr_fire && !busy && wb_adr_i == FSPC_OFS_UPPER && wb_sel_i[0]) begin
         upper_q <= wb_dat_i[7:0];
      end
      if (wr_fire && !busy && wb_adr_i == FSPC_OFS_LOWER) begin
         if (wb_sel_i[0]) begin
            lower_q[7:0] <= wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            lower_q[15:8] <= wb_dat_i[15:8];
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         page_q <= FSPC_PAGE_RST;
      end else if (wr_fire && wb_adr_i == FSPC_OFS_PAGE && wb_sel_i[0]) begin
         page_q <= wb_dat_i[7:0];
      end
   end

   always_comb begin
      mem_we = tbl_valid && tbl_ready && tbl_req.write;
      mem_be = 3'h0;
      mem_wd = 24'h000000;
      if (!tbl_req.high && !tbl_req.byte_mode) begin
         mem_be = 3'h3;
         mem_wd = {8'h00, tbl_req.wdata};
      end else if (!tbl_req.high) begin
         mem_be = tbl_req.ea[0] ? 3'h2 : 3'h1;
         mem_wd = {8'h00, tbl_req.wdata[7:0], tbl_req.wdata[7:0]};
      end else if (!tbl_req.byte_mode || !tbl_req.ea[0]) begin
         mem_be = 3'h4;
         mem_wd = {tbl_req.wdata[7:0], 16'h0000};
      end
   end

   fspc_latch_mem u_latch (
      .clk    (clk),
      .we     (mem_we),
      .widx   (tbl_req.ea[1]),
      .wbe    (mem_be),
      .wdata  (mem_wd),
      .rdata0 (mem_rd0),
      .rdata1 (mem_rd1)
   );

   // Sequencer for fetches and array operations
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= FSPC_ST_IDLE;
      end else if (sys_rst) begin
         state_q <= FSPC_ST_IDLE;
      end else begin
         case (state_q)
            FSPC_ST_IDLE: begin
               if (accept) begin
                  state_q <= FSPC_ST_LOAD;
               end else if (tbl_valid && !tbl_req.write) begin
                  state_q <= FSPC_ST_FETCH;
               end
            end
            FSPC_ST_FETCH: if (fl_rd_ack) state_q <= FSPC_ST_IDLE;
            FSPC_ST_LOAD:  state_q <= FSPC_ST_ISSUE;
            FSPC_ST_ISSUE: state_q <= FSPC_ST_WAIT;
            FSPC_ST_WAIT:  if (fl_done) state_q <= FSPC_ST_IDLE;
            default:       state_q <= FSPC_ST_IDLE;
         endcase
      end
   end

   // Array command: read, erase and program are one-cycle pulses
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cmd_q <= '0;
      end else begin
         cmd_q.read  <= 1'b0;
         cmd_q.erase <= 1'b0;
         cmd_q.prog  <= 1'b0;
         if (state_q == FSPC_ST_IDLE && tbl_valid && !tbl_req.write
             && !accept && !sys_rst) begin
            cmd_q.read <= 1'b1;
            cmd_q.addr <= fspc_addr(page_q, tbl_req.ea);
            cmd_q.cfg  <= page_q[7];
         end else if (state_q == FSPC_ST_ISSUE && !sys_rst) begin
            cmd_q.cfg <= upper_q[7];
            if (op_q == FSPC_OP_ERASE) begin
               cmd_q.erase <= 1'b1;
               cmd_q.addr  <= op_addr & FSPC_PAGE_MASK;
            end else begin
               cmd_q.prog   <= 1'b1;
               cmd_q.addr   <= op_addr & FSPC_PAIR_MASK;
               cmd_q.wdata0 <= mem_rd0;
               cmd_q.wdata1 <= mem_rd1;
            end
         end
      end
   end

   // Fetch answer shaping
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hold_q   <= '0;
         rvalid_q <= 1'b0;
         rdata_q  <= 16'h0000;
      end else begin
         rvalid_q <= 1'b0;
         if (state_q == FSPC_ST_IDLE && tbl_valid) begin
            hold_q <= tbl_req;
         end
         if (state_q == FSPC_ST_FETCH && fl_rd_ack && !sys_rst) begin
            rvalid_q <= 1'b1;
            if (!hold_q.high && !hold_q.byte_mode) begin
               rdata_q <= fl_rdata[15:0];
            end else if (!hold_q.high) begin
               rdata_q <= {8'h00, hold_q.ea[0] ? fl_rdata[15:8]
                                               : fl_rdata[7:0]};
            end else if (!hold_q.byte_mode || !hold_q.ea[0]) begin
               rdata_q <= {8'h00, fl_rdata[23:16]};
            end else begin
               rdata_q <= 16'h0000;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stby_out_q <= 1'b0;
         wake_q     <= 16'h0000;
         ready_q    <= 1'b1;
      end else begin
         stby_out_q <= idle_in && stby_q;
         if (stby_out_q) begin
            wake_q <= 16'(FSPC_WAKE_CYC);
         end else if (wake_q != 16'h0000) begin
            wake_q <= wake_q - 16'h0001;
         end
         ready_q <= !stby_out_q && (wake_q <= 16'h0001)
                 && !(idle_in && stby_q);
      end
   end

   sequence s_issue;
      state_q == FSPC_ST_ISSUE && !sys_rst;
   endsequence

   sequence s_pulse;
      cmd_q.erase || cmd_q.prog;
   endsequence

   launch_issue_a: assert property (
      @(posedge clk) disable iff (!rstn || sys_rst)
      accept |=> (start_q && cpu_stall) ##1 s_issue ##1 s_pulse)
      else $error("accepted start did not reach the array");

   done_clear_a: assert property (
      @(posedge clk) disable iff (!rstn)
      (state_q == FSPC_ST_WAIT && fl_done && !sys_rst)
      |=> !start_q && !cpu_stall && !fault_q)
      else $error("start bit or stall kept after completion");

   bad_fault_a: assert property (
      @(posedge clk) disable iff (!rstn)
      bad_start |=> fault_q && !start_q ##1 !(cmd_q.erase || cmd_q.prog))
      else $error("refused start did not raise fault");

   reserved_op_a: assert property (
      @(posedge clk) disable iff (!rstn)
      s_pulse |-> ($past(op_q) == FSPC_OP_ERASE) == cmd_q.erase
                  && op_valid)
      else $error("array pulse does not match operation code");

   erase_align_a: assert property (
      @(posedge clk) disable iff (!rstn)
      cmd_q.erase |-> cmd_q.addr[10:0] == 11'h000)
      else $error("erase address not page aligned");

   fetch_addr_a: assert property (
      @(posedge clk) disable iff (!rstn)
      cmd_q.read |-> cmd_q.addr == {$past(page_q), $past(tbl_req.ea)}
                     && cmd_q.cfg == $past(page_q[7]))
      else $error("fetch address not page select plus EA");

   phantom_zero_a: assert property (
      @(posedge clk) disable iff (!rstn)
      tbl_rvalid && hold_q.high |-> tbl_rdata[15:8] == 8'h00)
      else $error("high fetch phantom byte not zero");

   power_save_instruction_block_a: assert property (
      @(posedge clk) disable iff (!rstn)
      cpu_stall |-> !power_save_instruction_ok)
      else $error("power-save taken during an operation");

   wake_hold_a: assert property (
      @(posedge clk) disable iff (!rstn)
      $fell(reg_standby) |-> (!flash_ready)[*8])
      else $error("flash ready before wake delay");

   por_only_a: assert property (
      @(posedge clk) disable iff (!rstn)
      sys_rst && !ctrl_wr |=> $stable(en_q) && $stable(op_q)
                             && $stable(stby_q))
      else $error("control bits changed by non power-on reset");
endmodule

// ---- design/fspc_latch_mem.sv ----
// Purpose: two-word write latch for double-word programming
// Assumes: byte lanes 0..2 of a 24-bit program word
// Notes:   both words are read out through registers every cycle
`timescale 1ns/1ps
module fspc_latch_mem (
   input  wire logic        clk,     // System clock
   input  wire logic        we,      // Write strobe
   input  wire logic        widx,    // Word index within the pair
   input  wire logic [2:0]  wbe,     // Byte enables
   input  wire logic [23:0] wdata,   // Write data
   output logic      [23:0] rdata0,  // First word, registered
   output logic      [23:0] rdata1   // Second word, registered
);
   logic [23:0] mem [2];

   always_ff @(posedge clk) begin
      for (int b = 0; b < 3; b++) begin
         if (we && wbe[b]) begin
            mem[widx][b*8 +: 8] <= wdata[b*8 +: 8];
         end
      end
   end

   always_ff @(posedge clk) begin
      rdata0 <= mem[0];
      rdata1 <= mem[1];
   end
endmodule

// ---- design/fspc_pkg.sv ----
// Purpose: shared constants and carrier types for the flash sequencer
// Assumes: 20 MHz system clock, 32-bit classic Wishbone register port
// Notes:   register offsets are byte addresses, one word per register
package fspc_pkg;
   // Register byte offsets
   localparam logic [7:0]  FSPC_OFS_CTRL  = 8'h00;
   localparam logic [7:0]  FSPC_OFS_UPPER = 8'h04;
   localparam logic [7:0]  FSPC_OFS_LOWER = 8'h08;
   localparam logic [7:0]  FSPC_OFS_KEY   = 8'h0C;
   localparam logic [7:0]  FSPC_OFS_PAGE  = 8'h10;
   // Control register fields
   localparam int          FSPC_START_BIT = 15;
   localparam int          FSPC_EN_BIT    = 14;
   localparam int          FSPC_FAULT_BIT = 13;
   localparam int          FSPC_STBY_BIT  = 12;
   localparam logic [15:0] FSPC_CTRL_RST  = 16'h0000;
   localparam logic [7:0]  FSPC_PAGE_RST  = 8'h00;
   // Operation select codes
   localparam logic [3:0]  FSPC_OP_PROG   = 4'h1;
   localparam logic [3:0]  FSPC_OP_ERASE  = 4'h3;
   // Unlock key bytes
   localparam logic [7:0]  FSPC_KEY_FIRST = 8'h55;
   localparam logic [7:0]  FSPC_KEY_SECOND = 8'hAA;
   // 1024 instructions per page, two address units each
   localparam logic [23:0] FSPC_PAGE_MASK = 24'hFFF800;
   localparam logic [23:0] FSPC_PAIR_MASK = 24'hFFFFFC;
   localparam logic [23:0] FSPC_WORD_STEP = 24'h000002;
   // Timing
   localparam int          FSPC_CLK_NS    = 50;
   localparam int          FSPC_WAKE_NS   = 10000;
   localparam int          FSPC_WAKE_CYC  =
      (FSPC_WAKE_NS + FSPC_CLK_NS - 1) / FSPC_CLK_NS;

   typedef struct packed {
      logic        write;
      logic        high;
      logic        byte_mode;
      logic [15:0] ea;
      logic [15:0] wdata;
   } fspc_tbl_req_t;

   typedef struct packed {
      logic        read;
      logic        erase;
      logic        prog;
      logic        cfg;
      logic [23:0] addr;
      logic [23:0] wdata0;
      logic [23:0] wdata1;
   } fspc_flash_cmd_t;

   typedef enum logic [1:0] {
      FSPC_KEY_LOCKED,
      FSPC_KEY_HALF,
      FSPC_KEY_OPEN
   } fspc_key_t;

   function automatic logic [23:0] fspc_addr(input logic [7:0]  hi,
                                             input logic [15:0] lo);
      return {hi, lo};
   endfunction
endpackage

// ---- testbench/fspc_flash_model.sv ----
// Purpose: behavioural program flash array facing the sequencer
// Assumes: commands sampled on clk, one operation at a time
// Notes:   slow stretches every answer; idle read data keeps toggling
`timescale 1ns/1ps
module fspc_flash_model
   import fspc_pkg::*;
(
   input  wire logic                     clk,       // System clock
   input  wire logic                     rstn,      // Power-on reset
   input  wire fspc_pkg::fspc_flash_cmd_t fl_cmd,   // Array command
   input  wire logic                     slow,      // Slow answers
   output logic                          fl_rd_ack, // Read answer
   output logic      [23:0]              fl_rdata,  // Read data
   output logic                          fl_done    // Operation done
);
   logic [23:0] mem [int];
   int          rcnt;
   int          dcnt;
   function automatic logic [23:0] rdw(input int a);
      return mem.exists(a) ? mem[a] : 24'hFFFFFF;
   endfunction
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rcnt = 0;
         dcnt = 0;
         fl_rd_ack <= 1'b0;
         fl_done <= 1'b0;
         fl_rdata <= 24'h000000;
      end else begin
         fl_rd_ack <= 1'b0;
         fl_done <= 1'b0;
         fl_rdata <= ~fl_rdata;
         if (fl_cmd.read)
            rcnt = slow ? 5 : 1;
         if (fl_cmd.erase) begin
            for (int i = 0; i < 2048; i += 2)
               mem[fl_cmd.addr + i] = 24'hFFFFFF;
            dcnt = slow ? 40 : 2;
         end
         if (fl_cmd.prog) begin
            mem[fl_cmd.addr] = rdw(fl_cmd.addr) & fl_cmd.wdata0;
            mem[fl_cmd.addr + 2] = rdw(fl_cmd.addr + 2) & fl_cmd.wdata1;
            dcnt = slow ? 30 : 2;
         end
         if (rcnt > 0) begin
            rcnt--;
            if (rcnt == 0) begin
               fl_rd_ack <= 1'b1;
               // Byte lane bit does not select a word
               fl_rdata <= rdw(fl_cmd.addr & 24'hFFFFFE);
            end
         end
         if (dcnt > 0) begin
            dcnt--;
            if (dcnt == 0)
               fl_done <= 1'b1;
         end
      end
   end
endmodule

// ---- testbench/tb.sv ----
// Purpose: self-checking bench for the flash sequencer
// Assumes: bench acts as core; array model on the far side
// Notes:   expected values come from the bench's own word store
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin errors++; \
   $display("BAD %s exp %0h got %0h", n, e, s); end end
module tb;
   import fspc_pkg::*;
   logic clk = 0, rstn = 0, sys_rst = 0, slow = 0, power_save_instruction_req = 0;
   logic cyc = 0, stb = 0, we = 0, idle_in = 0, tbl_valid = 0;
   logic [7:0] adr = 0;
   logic [3:0] sel = 0;
   logic [31:0] wdat = 0, rdat, rv;
   logic ack, tbl_ready, tbl_rvalid, fl_rd_ack, fl_done, cpu_stall;
   logic power_save_instruction_ok, reg_standby, flash_ready;
   logic [15:0] tbl_rdata;
   logic [23:0] fl_rdata, pa;
   fspc_tbl_req_t tbl_req = '0;
   fspc_flash_cmd_t fl_cmd, cap, rd_cap;
   int errors = 0, checked = 0, ncmd = 0, n;
   logic [23:0] wv [2];
   fspc_ctrl u_fspc_ctrl (.clk(clk), .rstn(rstn), .sys_rst(sys_rst),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .tbl_valid(tbl_valid), .tbl_req(tbl_req), .tbl_ready(tbl_ready),
      .tbl_rvalid(tbl_rvalid), .tbl_rdata(tbl_rdata), .fl_cmd(fl_cmd),
      .fl_rd_ack(fl_rd_ack), .fl_rdata(fl_rdata), .fl_done(fl_done),
      .cpu_stall(cpu_stall), .power_save_instruction_req(power_save_instruction_req),
      .power_save_instruction_ok(power_save_instruction_ok), .idle_in(idle_in),
      .reg_standby(reg_standby), .flash_ready(flash_ready));
   fspc_flash_model u_fspc_flash_model (.clk(clk), .rstn(rstn),
      .fl_cmd(fl_cmd), .slow(slow), .fl_rd_ack(fl_rd_ack),
      .fl_rdata(fl_rdata), .fl_done(fl_done));
   always #25 clk = ~clk;
   always @(posedge clk) begin
      if (fl_cmd.erase || fl_cmd.prog) begin
         cap = fl_cmd;
         ncmd++;
      end
      if (fl_cmd.read)
         rd_cap = fl_cmd;
   end
   task automatic wb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
      int k;
      @(posedge clk);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'h3;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 20);
      `CHK("ack", 1'b1, ack)
      rv = rdat;
      cyc <= 0;
      stb <= 0;
      sel <= 4'h0;
   endtask
   task automatic tbl(input logic w, h, b, input logic [15:0] ea, d);
      int k;
      @(posedge clk);
      tbl_valid <= 1;
      tbl_req <= {w, h, b, ea, d};
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (tbl_ready !== 1'b1 && k < 50);
      if (tbl_ready !== 1'b1)
         errors++;
      tbl_valid <= 0;
      k = 0;
      while (!w && tbl_rvalid !== 1'b1 && k < 50) begin
         @(posedge clk);
         k++;
      end
      if (!w && tbl_rvalid !== 1'b1)
         errors++;
      rv = {16'h0, tbl_rdata};
   endtask
   task automatic run(input logic [3:0] op, input logic en, ky);
      logic acc;
      int c0;
      acc = en && ky && (op == 4'h1 || op == 4'h3);
      slow <= 1'($urandom);
      wb(FSPC_OFS_CTRL, 1, {17'h0, en, 10'h0, op});
      if (ky) begin
         wb(FSPC_OFS_KEY, 1, 32'h55);
         wb(FSPC_OFS_KEY, 1, 32'hAA);
      end
      c0 = ncmd;
      power_save_instruction_req <= 1;
      wb(FSPC_OFS_CTRL, 1, {16'h0, 1'b1, en, 10'h0, op});
      `CHK("stall", acc, cpu_stall)
      `CHK("psave", !acc, power_save_instruction_ok)
      n = 0;
      while (cpu_stall === 1'b1 && n < 300) begin
         @(posedge clk);
         n++;
      end
      power_save_instruction_req <= 0;
      wb(FSPC_OFS_CTRL, 0, 0);
      `CHK("ctrl", {17'h0, en, !acc, 9'h0, op}, rv)
      `CHK("cmds", c0 + acc, ncmd)
      if (acc && op == 4'h3)
         `CHK("eaddr", pa & 24'hFFF800, cap.addr)
      if (acc && op == 4'h1) begin
         `CHK("paddr", pa, cap.addr)
         `CHK("word0", wv[0], cap.wdata0)
         `CHK("word1", wv[1], cap.wdata1)
      end
   endtask
   function automatic logic [15:0] expf(logic [23:0] w, logic h, b, e);
      if (!b)
         return h ? {8'h0, w[23:16]} : w[15:0];
      if (h)
         return e ? 16'h0 : {8'h0, w[23:16]};
      return e ? {8'h0, w[15:8]} : {8'h0, w[7:0]};
   endfunction
   task end_of_test;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #2000000;
      errors++;
      end_of_test;
   end
   initial begin
      logic [7:0] ra [4];
      logic [15:0] ea;
      ra = '{FSPC_OFS_CTRL, FSPC_OFS_KEY, FSPC_OFS_PAGE, 8'h1C};
      void'($urandom(17));
      repeat (5) @(posedge clk);
      rstn <= 1;
      for (int i = 0; i < 4; i++) begin
         wb(ra[i], 0, 0);
         `CHK("rstval", 32'h0, rv)
      end
      pa = 24'($urandom) & 24'h7FFFFC;
      wv[0] = 24'($urandom);
      wv[1] = 24'($urandom);
      wb(FSPC_OFS_UPPER, 1, {16'h0, 8'hFF, pa[23:16]});
      wb(FSPC_OFS_UPPER, 0, 0);
      `CHK("upper", {24'h0, pa[23:16]}, rv)
      wb(FSPC_OFS_LOWER, 1, {16'h0, pa[15:0]});
      wb(FSPC_OFS_LOWER, 0, 0);
      `CHK("lower", {16'h0, pa[15:0]}, rv)
      for (int j = 0; j < 2; j++) begin
         tbl(1, 0, 0, pa[15:0] + 16'(2 * j), wv[j][15:0]);
         tbl(1, 1, 0, pa[15:0] + 16'(2 * j), {8'h0, wv[j][23:16]});
      end
      for (int i = 15; i >= 0; i--)
         run(4'(i), 1, 1);
      run(4'h3, 0, 1);
      run(4'h3, 1, 0);
      wb(FSPC_OFS_PAGE, 1, {24'h0, pa[23:16]});
      for (int j = 0; j < 2; j++)
         for (int m = 0; m < 8; m++)
            if (m[1] || !m[0]) begin
               ea = pa[15:0] + 16'(2 * j + m[0]);
               tbl(0, m[2], m[1], ea, 0);
               `CHK("fetch", expf(wv[j], m[2], m[1], m[0]), rv[15:0])
               `CHK("raddr", {pa[23:16], ea}, rd_cap.addr)
            end
      wb(FSPC_OFS_PAGE, 1, 32'h80);
      tbl(0, 0, 0, 16'h0, 0);
      `CHK("cfg", 1'b1, rd_cap.cfg)
      wb(FSPC_OFS_CTRL, 1, 32'h1000);
      idle_in <= 1;
      repeat (3) @(posedge clk);
      `CHK("stby", 1'b1, reg_standby)
      idle_in <= 0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (flash_ready !== 1'b1 && n < 1000);
      `CHK("wake", 1'b1, n >= FSPC_WAKE_CYC - 2 && n < FSPC_WAKE_CYC + 4)
      wb(FSPC_OFS_CTRL, 1, 32'h4003);
      idle_in <= 1;
      repeat (3) @(posedge clk);
      `CHK("active", 1'b0, reg_standby)
      idle_in <= 0;
      sys_rst <= 1;
      @(posedge clk);
      sys_rst <= 0;
      wb(FSPC_OFS_CTRL, 0, 0);
      `CHK("keep", 32'h4003, rv)
      // Other reset in mid operation terminates it
      wb(FSPC_OFS_KEY, 1, 32'h55);
      wb(FSPC_OFS_KEY, 1, 32'hAA);
      wb(FSPC_OFS_CTRL, 1, 32'hC003);
      sys_rst <= 1;
      @(posedge clk);
      sys_rst <= 0;
      wb(FSPC_OFS_CTRL, 0, 0);
      `CHK("term", 32'h6003, rv)
      `CHK("abort", 1'b0, cpu_stall)
      end_of_test;
   end
endmodule
